// file: rtl/cmp16_pkg.sv
// Behaviour
// - pair-move source code maps 0,17,2,3,16,18,19,20
// - pair-move sources from bits 6..4, 3..1
// - pair-move copies both sources into destination pair
// - destination code selects one of eight pairs
// - pair-move transfers happen atomically in one cycle
// - invert writes source XOR all ones
// - ALU selectors reach registers 2-7, 16, 17
// - OR result written back into destination register (bits 9..7)
// - byte store: low byte, base plus offset
// - store base and data selector ranges
// - lane select and address adjusted for endianness
// - store data shifted left by eight per lane
// - halfword store: low half, offset times two
// - odd halfword address raises error, no write
// - breakpoint in debug mode sets cause code
// - breakpoint immediate field is ignored
// - shift code 0 means 8, else itself
// - left shift fills zeros
// - right shift fills zeros
// - subtract wraps, never flags overflow
package cmp16_pkg;
  localparam logic [11:0] ADDR_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_CFG   = 12'h004;
  localparam logic [11:0] ADDR_STAT  = 12'h008;
  localparam logic [11:0] ADDR_SADDR = 12'h00c;
  localparam logic [4:0]  GPR_PAGE   = 5'h02;
  localparam int          CTRL_OP_LSB = 16;
  localparam int          CFG_BIG    = 0;
  localparam int          CFG_REV    = 1;
  localparam int          CFG_DBG    = 2;
  localparam int          STAT_ERR   = 8;
  localparam int          STAT_BRK   = 9;
  localparam int          FLD_DEST   = 7;
  localparam int          FLD_A      = 4;
  localparam int          FLD_B      = 1;
  localparam logic [4:0]  BP_CAUSE   = 5'h09;
  localparam logic [31:0] ALL_ONES   = 32'hffffffff;
  localparam logic [5:0]  SA_ZERO_AMT = 6'h08;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [2:0]  CFG_RST    = 3'h0;
  localparam logic [3:0]  OP_PAIR    = 4'h0;
  localparam logic [3:0]  OP_INV     = 4'h1;
  localparam logic [3:0]  OP_OR      = 4'h2;
  localparam logic [3:0]  OP_SB      = 4'h3;
  localparam logic [3:0]  OP_SH      = 4'h4;
  localparam logic [3:0]  OP_BRK     = 4'h5;
  localparam logic [3:0]  OP_SLL     = 4'h6;
  localparam logic [3:0]  OP_SRL     = 4'h7;
  localparam logic [3:0]  OP_SUB     = 4'h8;

  // pair-move source decode
  function automatic logic [4:0] pairSrc(input logic [2:0] c);
    logic [4:0] r;
    r = 5'h00;
    case (c)
      3'h0: r = 5'h00;
      3'h1: r = 5'h11;
      3'h2: r = 5'h02;
      3'h3: r = 5'h03;
      3'h4: r = 5'h10;
      3'h5: r = 5'h12;
      3'h6: r = 5'h13;
      default: r = 5'h14;
    endcase
    return r;
  endfunction

  // destination pair decode, first in [9:5], second in [4:0]
  function automatic logic [9:0] pairDst(input logic [2:0] c);
    logic [9:0] r;
    r = 10'h000;
    case (c)
      3'h0: r = {5'h05, 5'h06};
      3'h1: r = {5'h05, 5'h07};
      3'h2: r = {5'h06, 5'h07};
      3'h3: r = {5'h04, 5'h15};
      3'h4: r = {5'h04, 5'h16};
      3'h5: r = {5'h04, 5'h05};
      3'h6: r = {5'h04, 5'h06};
      default: r = {5'h04, 5'h07};
    endcase
    return r;
  endfunction

  // alu and store-base decode: 16, 17, 2..7
  function automatic logic [4:0] aluSel(input logic [2:0] c);
    return (c < 3'h2) ? {4'h8, c[0]} : {2'h0, c};
  endfunction

  // store data decode: 0, 17, 2..7
  function automatic logic [4:0] dataSel(input logic [2:0] c);
    return (c == 3'h1) ? 5'h11 : {2'h0, c};
  endfunction
endpackage

// file: rtl/compact_16bit_instr_exec.sv
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module compact_16bit_instr_exec (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             storeValid,
  output logic [31:0]      storeAddr,
  output logic [31:0]      storeData,
  output logic [1:0]       storeLane,
  output logic             storeHalf,
  output logic             addrError,
  output logic             debugBreak,
  output logic             debugModeBreak
);
  typedef struct packed {
    logic [31:0][31:0] gpr;
    logic              awReady;
    logic              wReady;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic              rValid;
    logic [1:0]        rResp;
    logic [31:0]       rData;
    logic [11:0]       awAddr;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              awHave;
    logic              wHave;
    logic [15:0]       instr;
    logic [3:0]        op;
    logic              pend;
    logic [2:0]        cfg;
    logic [4:0]        cause;
    logic              lastErr;
    logic              lastBrk;
    logic              stValid;
    logic [31:0]       stAddr;
    logic [31:0]       stData;
    logic [1:0]        stLane;
    logic              stHalf;
    logic              aErr;
    logic              dBrk;
    logic              dmBrk;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  localparam int FD = cmp16_pkg::FLD_DEST;
  localparam int FA = cmp16_pkg::FLD_A;
  localparam int FB = cmp16_pkg::FLD_B;

  function automatic logic [31:0] rg(input logic [4:0] i);
    return (i == 5'h00) ? 32'h00000000 : s_r.gpr[i];
  endfunction

  always_comb begin
    logic [4:0]  dA;
    logic [4:0]  dB;
    logic [9:0]  dp;
    logic [31:0] va;
    logic [31:0] vb;
    logic [31:0] ea;
    logic [1:0]  bsel;
    logic [1:0]  psel;
    logic [5:0]  sa;
    logic [11:0] wa;
    logic [11:0] ra;
    logic        wOk;
    logic [31:0] cw;
    s_nxt = s_r;
    cw = 32'h00000000;
    dA = 5'h00;
    dB = 5'h00;
    dp = 10'h000;
    va = 32'h00000000;
    vb = 32'h00000000;
    ea = 32'h00000000;
    bsel = 2'h0;
    psel = 2'h0;
    sa = 6'h00;
    wa = s_r.awAddr;
    ra = araddr;
    wOk = 1'b0;
    s_nxt.stValid = 1'b0;
    s_nxt.aErr = 1'b0;
    s_nxt.dBrk = 1'b0;
    s_nxt.dmBrk = 1'b0;

    // write channel capture, either order
    if (awvalid && s_r.awReady) begin
      s_nxt.awAddr = awaddr;
      s_nxt.awHave = 1'b1;
      s_nxt.awReady = 1'b0;
    end
    if (wvalid && s_r.wReady) begin
      s_nxt.wData = wdata;
      s_nxt.wStrb = wstrb;
      s_nxt.wHave = 1'b1;
      s_nxt.wReady = 1'b0;
    end
    if (s_r.awHave && s_r.wHave && !s_r.bValid) begin
      s_nxt.awHave = 1'b0;
      s_nxt.wHave = 1'b0;
      s_nxt.bValid = 1'b1;
      wOk = 1'b1;
      if (wa[11:7] == cmp16_pkg::GPR_PAGE) begin
        if (wa[6:2] != 5'h00) begin
          s_nxt.gpr[wa[6:2]] = merge(s_r.gpr[wa[6:2]], s_r.wData, s_r.wStrb);
        end
      end else if (wa == cmp16_pkg::ADDR_CTRL) begin
        cw = merge({16'h0000, s_r.instr}, s_r.wData, s_r.wStrb);
        s_nxt.instr = cw[15:0];
        s_nxt.op = s_r.wStrb[2] ? s_r.wData[cmp16_pkg::CTRL_OP_LSB +: 4] : s_r.op;
        s_nxt.pend = 1'b1;
      end else if (wa == cmp16_pkg::ADDR_CFG) begin
        if (s_r.wStrb[0]) begin
          s_nxt.cfg = s_r.wData[2:0];
        end
      end else begin
        wOk = 1'b0;
      end
      s_nxt.bResp = wOk ? cmp16_pkg::RESP_OKAY : cmp16_pkg::RESP_SLVERR;
    end
    if (s_r.bValid && bready) begin
      s_nxt.bValid = 1'b0;
      s_nxt.awReady = 1'b1;
      s_nxt.wReady = 1'b1;
    end

    // read channel
    if (arvalid && s_r.arReady) begin
      s_nxt.arReady = 1'b0;
      s_nxt.rValid = 1'b1;
      s_nxt.rResp = cmp16_pkg::RESP_OKAY;
      s_nxt.rData = 32'h00000000;
      if (ra[11:7] == cmp16_pkg::GPR_PAGE) begin
        s_nxt.rData = (ra[6:2] == 5'h00) ? 32'h00000000 : s_r.gpr[ra[6:2]];
      end else if (ra == cmp16_pkg::ADDR_CTRL) begin
        s_nxt.rData = {12'h000, s_r.op, s_r.instr};
      end else if (ra == cmp16_pkg::ADDR_CFG) begin
        s_nxt.rData = {29'h00000000, s_r.cfg};
      end else if (ra == cmp16_pkg::ADDR_STAT) begin
        s_nxt.rData = {22'h000000, s_r.lastBrk, s_r.lastErr, 3'h0, s_r.cause};
      end else if (ra == cmp16_pkg::ADDR_SADDR) begin
        s_nxt.rData = s_r.stAddr;
      end else begin
        s_nxt.rResp = cmp16_pkg::RESP_SLVERR;
      end
    end
    if (s_r.rValid && rready) begin
      s_nxt.rValid = 1'b0;
      s_nxt.arReady = 1'b1;
    end

    // execute the instruction posted through the control register
    if (s_r.pend) begin
      s_nxt.pend = 1'b0;
      s_nxt.lastErr = 1'b0;
      s_nxt.lastBrk = 1'b0;
      sa = (s_r.instr[3:1] == 3'h0) ? cmp16_pkg::SA_ZERO_AMT
                                    : {3'h0, s_r.instr[3:1]};
      dA = cmp16_pkg::aluSel(s_r.instr[FA +: 3]);
      dB = cmp16_pkg::aluSel(s_r.instr[FB +: 3]);
      dp = {cmp16_pkg::aluSel(s_r.instr[FD +: 3]), 5'h00};
      va = rg(dA);
      vb = rg(dB);
      case (s_r.op)
        cmp16_pkg::OP_PAIR: begin
          dp = cmp16_pkg::pairDst(s_r.instr[FD +: 3]);
          va = rg(cmp16_pkg::pairSrc(s_r.instr[FB +: 3]));
          vb = rg(cmp16_pkg::pairSrc(s_r.instr[FA +: 3]));
          // both writes land in the same edge
          s_nxt.gpr[dp[9:5]] = va;
          s_nxt.gpr[dp[4:0]] = vb;
        end
        cmp16_pkg::OP_INV: begin
          s_nxt.gpr[dp[9:5]] = va ^ cmp16_pkg::ALL_ONES;
        end
        cmp16_pkg::OP_OR: begin
          s_nxt.gpr[dp[9:5]] = va | rg(dp[9:5]);
        end
        cmp16_pkg::OP_SLL: begin
          s_nxt.gpr[dp[9:5]] = va << sa;
        end
        cmp16_pkg::OP_SRL: begin
          s_nxt.gpr[dp[9:5]] = va >> sa;
        end
        cmp16_pkg::OP_SUB: begin
          s_nxt.gpr[dp[9:5]] = va - vb;
        end
        cmp16_pkg::OP_SB, cmp16_pkg::OP_SH: begin
          vb = rg(cmp16_pkg::dataSel(s_r.instr[FD +: 3]));
          if (s_r.op == cmp16_pkg::OP_SB) begin
            ea = va + {28'h0000000, s_r.instr[3:0]};
            bsel = ea[1:0] ^ {2{s_r.cfg[cmp16_pkg::CFG_BIG]}};
            psel = ea[1:0] ^ {2{s_r.cfg[cmp16_pkg::CFG_REV]}};
            vb = {24'h000000, vb[7:0]};
          end else begin
            ea = va + {27'h0000000, s_r.instr[3:0], 1'b0};
            bsel = ea[1:0] ^ {s_r.cfg[cmp16_pkg::CFG_BIG], 1'b0};
            psel = ea[1:0] ^ {s_r.cfg[cmp16_pkg::CFG_REV], 1'b0};
            vb = {16'h0000, vb[15:0]};
          end
          if (s_r.op == cmp16_pkg::OP_SH && ea[0]) begin
            s_nxt.aErr = 1'b1;
            s_nxt.lastErr = 1'b1;
          end else begin
            // byte stores skip any alignment
            s_nxt.stValid = 1'b1;
            s_nxt.stAddr = {ea[31:2], psel};
            s_nxt.stData = vb << {bsel, 3'h0};
            s_nxt.stLane = bsel;
            s_nxt.stHalf = (s_r.op == cmp16_pkg::OP_SH);
          end
        end
        cmp16_pkg::OP_BRK: begin
          // immediate code bits are not looked at
          s_nxt.lastBrk = 1'b1;
          if (!s_r.cfg[cmp16_pkg::CFG_DBG]) begin
            s_nxt.dBrk = 1'b1;
          end else begin
            s_nxt.dmBrk = 1'b1;
            s_nxt.cause = cmp16_pkg::BP_CAUSE;
          end
        end
        default: begin
          s_nxt.lastErr = 1'b0;
        end
      endcase
      s_nxt.gpr[0] = 32'h00000000;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.awReady <= 1'b1;
      s_r.wReady <= 1'b1;
      s_r.arReady <= 1'b1;
      s_r.cfg <= cmp16_pkg::CFG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready        = s_r.awReady;
  assign wready         = s_r.wReady;
  assign bresp          = s_r.bResp;
  assign bvalid         = s_r.bValid;
  assign arready        = s_r.arReady;
  assign rdata          = s_r.rData;
  assign rresp          = s_r.rResp;
  assign rvalid         = s_r.rValid;
  assign storeValid     = s_r.stValid;
  assign storeAddr      = s_r.stAddr;
  assign storeData      = s_r.stData;
  assign storeLane      = s_r.stLane;
  assign storeHalf      = s_r.stHalf;
  assign addrError      = s_r.aErr;
  assign debugBreak     = s_r.dBrk;
  assign debugModeBreak = s_r.dmBrk;
endmodule

// file: test/compact_16bit_instr_exec_monitor.sv
`timescale 1ns/1ps
module compact_16bit_instr_exec_monitor (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        bvalid,
  input wire logic        storeValid,
  input wire logic [31:0] storeAddr,
  input wire logic [31:0] storeData,
  input wire logic [1:0]  storeLane,
  input wire logic        storeHalf,
  input wire logic        addrError,
  input wire logic        debugBreak,
  input wire logic        debugModeBreak
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_err_nostore: assert property (addrError |-> !storeValid)
    else $error("store issued with address error");
  a_err_pulse: assert property (addrError |=> !addrError [*2])
    else $error("address error longer than one cycle");
  a_lane_zeros: assert property (storeValid |->
    (storeData & ((32'h1 << {storeLane, 3'b000}) - 32'h1)) == 32'h0)
    else $error("store data not shifted to lane");
  a_half_lane: assert property (storeValid && storeHalf |-> !storeLane[0] && !storeAddr[0])
    else $error("halfword store on odd lane");
  a_store_cause: assert property (storeValid |-> $past(bvalid))
    else $error("store without a control write");
  a_brk_excl: assert property (debugBreak |-> !debugModeBreak && !storeValid)
    else $error("both breakpoint kinds raised");
  a_brk_pulse: assert property ($rose(debugModeBreak) |=> !debugModeBreak)
    else $error("debug mode breakpoint longer than one cycle");
  a_brk_cause: assert property (debugBreak || debugModeBreak |-> $past(bvalid))
    else $error("breakpoint without a control write");
  c_half: cover property (storeValid && storeHalf);
  c_err: cover property (addrError);
  c_dbg: cover property (debugModeBreak);
endmodule
bind compact_16bit_instr_exec compact_16bit_instr_exec_monitor u_mon (.clock, .nrst, .bvalid,
  .storeValid, .storeAddr, .storeData, .storeLane, .storeHalf, .addrError, .debugBreak,
  .debugModeBreak);

// file: test/store_sink.sv
`timescale 1ns/1ps
module store_sink (
  input wire logic        clock,
  input wire logic        storeValid,
  input wire logic [31:0] storeAddr,
  input wire logic [31:0] storeData,
  input wire logic [1:0]  storeLane,
  input wire logic        storeHalf,
  input wire logic [3:0]  peekIdx,
  output logic [31:0]     peekWord
);
  logic [31:0] mem [16];
  initial for (int i = 0; i < 16; i++) mem[i] = 32'h0;
  // byte lanes picked by lane select, two for a halfword
  always @(posedge clock)
    if (storeValid)
      for (int b = 0; b < 4; b++)
        if (b == storeLane || (storeHalf && b == storeLane + 1))
          mem[storeAddr[5:2]][8*b +: 8] <= storeData[8*b +: 8];
  assign peekWord = mem[peekIdx];
endmodule

// file: test/compact_16bit_instr_exec_tb.sv
`timescale 1ns/1ps
module compact_16bit_instr_exec_tb;
  logic        clock, nrst, awvalid, wvalid, bready, arvalid, rready, h;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        storeValid, storeHalf, addrError, debugBreak, debugModeBreak;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, storeAddr, storeData, peekWord, readVal, a, pa;
  logic [3:0]  wstrb, peekIdx;
  logic [1:0]  bresp, rresp, storeLane, readResp, ln, writeResp;
  logic [31:0] m [32];
  int          numErrors, cmpCount;
  localparam logic [4:0] PS [8] = '{5'h00, 5'h11, 5'h02, 5'h03, 5'h10, 5'h12, 5'h13, 5'h14};
  localparam logic [4:0] AL [8] = '{5'h10, 5'h11, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07};
  localparam logic [4:0] DA [8] = '{5'h05, 5'h05, 5'h06, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04};
  localparam logic [4:0] DB [8] = '{5'h06, 5'h07, 5'h07, 5'h15, 5'h16, 5'h05, 5'h06, 5'h07};
  localparam logic [19:0] ROWS [15] = '{20'h802a6, 20'h00070, 20'h000e2, 20'h00154, 20'h001c6,
    20'h00238, 20'h002aa, 20'h0031c, 20'h0038e, 20'h100a0, 20'h20030, 20'h60250, 20'h6037e,
    20'h70110, 20'h7018a};

  compact_16bit_instr_exec u_dut (.clock, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .storeValid, .storeAddr, .storeData, .storeLane, .storeHalf,
    .addrError, .debugBreak, .debugModeBreak);
  store_sink u_mem (.clock, .storeValid, .storeAddr, .storeData, .storeLane, .storeHalf,
    .peekIdx, .peekWord);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic closeOut();
    $display("compares %0d errors %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge clock);
    awaddr  <= ad;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    repeat (200) begin
      @(posedge clock);
      awvalid <= awvalid & ~awready;
      wvalid  <= wvalid & ~wready;
      if (bvalid) begin
        writeResp = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic rdReg(input logic [11:0] ad);
    @(posedge clock);
    araddr  <= ad;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    repeat (200) begin
      @(posedge clock);
      arvalid <= arvalid & ~arready;
      if (rvalid) break;
    end
    readVal  = rdata;
    readResp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [11:0] gA(input logic [4:0] n);
    return 12'h100 + {5'h00, n, 2'b00};
  endfunction

  // reference model of one instruction, then read back the destinations
  task automatic execRow(input logic [19:0] r);
    logic [4:0]  t, u;
    logic [31:0] va;
    t = AL[r[9:7]];
    u = DB[r[9:7]];
    va = m[AL[r[6:4]]];
    case (r[19:16])
      4'h0: begin
        t = DA[r[9:7]];
        va = m[PS[r[3:1]]];
        m[u] = m[PS[r[6:4]]];
      end
      4'h1: va = va ^ 32'hffffffff;
      4'h2: va = va | m[t];
      4'h6: va = va << ((r[3:1] == 3'h0) ? 4'h8 : {1'b0, r[3:1]});
      4'h7: va = va >> ((r[3:1] == 3'h0) ? 4'h8 : {1'b0, r[3:1]});
      default: va = va - m[AL[r[3:1]]];
    endcase
    m[t] = va;
    wr(cmp16_pkg::ADDR_CTRL, {12'h000, r});
    rdReg(gA(t));
    chk("result", readVal, va);
    if (r[19:16] == 4'h0) begin
      rdReg(gA(u));
      chk("pair second", readVal, m[u]);
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    numErrors++;
    closeOut();
  end

  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    peekIdx = 4'h0;
    repeat (20) @(posedge clock);
    chk("reset", {awready, wready, arready, bvalid, rvalid, storeValid, addrError,
        debugBreak, debugModeBreak}, 32'h000001c0);
    nrst <= 1'b1;
    rdReg(cmp16_pkg::ADDR_CFG);
    chk("cfg reset", readVal, 32'h0);
    rdReg(12'h080);
    chk("unmapped resp", readResp, cmp16_pkg::RESP_SLVERR);
    chk("unmapped data", readVal, 32'h0);
    wr(12'h080, 32'h00000001);
    chk("unmapped write", writeResp, cmp16_pkg::RESP_SLVERR);
    for (int n = 0; n < 23; n++) begin
      wr(gA(5'(n)), 32'h80000001 + 32'(n) * 32'h01020304);
      m[n] = (n == 0) ? 32'h0 : 32'h80000001 + 32'(n) * 32'h01020304;
    end
    chk("write okay", writeResp, cmp16_pkg::RESP_OKAY);
    rdReg(gA(5'h00));
    chk("zero reg", readVal, 32'h0);
    // each instruction issued alone, never in a delay slot
    foreach (ROWS[i]) execRow(ROWS[i]);
    wr(gA(5'h06), 32'h00001002);
    wr(gA(5'h07), 32'h00002005);
    m[6] = 32'h00001002;
    m[7] = 32'h00002005;
    for (int c = 0; c < 8; c++) begin
      h = c[0];
      wr(cmp16_pkg::ADDR_CFG, {30'h0, c[2:1]});
      a = h ? m[6] + 32'h6 : m[7] + 32'hc;
      ln = a[1:0] ^ {c[1], c[1] & ~h};
      pa = {a[31:2], a[1:0] ^ {c[2], c[2] & ~h}};
      wr(cmp16_pkg::ADDR_CTRL, h ? 32'h000400e3 : 32'h000300fc);
      #1;
      chk("store", {storeValid, addrError, storeHalf, storeLane}, {2'b10, h, ln});
      chk("address", storeAddr, pa);
      chk("data", storeData, (m[17] & (h ? 32'hffff : 32'hff)) << {ln, 3'b000});
      @(posedge clock);
      #1;
      peekIdx = pa[5:2];
      #1;
      chk("memory", (peekWord >> {ln, 3'b000}) & (h ? 32'hffff : 32'hff),
          m[17] & (h ? 32'hffff : 32'hff));
    end
    wr(cmp16_pkg::ADDR_CTRL, 32'h000400f3);
    #1;
    chk("odd half", {storeValid, addrError}, 2'b01);
    rdReg(cmp16_pkg::ADDR_STAT);
    chk("error flag", readVal[8], 1'b1);
    for (int d = 0; d < 2; d++) begin
      wr(cmp16_pkg::ADDR_CFG, {29'h0, d[0], 2'b00});
      wr(cmp16_pkg::ADDR_CTRL, 32'h0005ffff);
      #1;
      chk("break kind", {debugBreak, debugModeBreak}, {~d[0], d[0]});
      rdReg(cmp16_pkg::ADDR_STAT);
      chk("break cause", {readVal[9], readVal[4:0]},
          {1'b1, d[0] ? cmp16_pkg::BP_CAUSE : 5'h00});
    end
    wr(cmp16_pkg::ADDR_CTRL, 32'h0009ffff);
    #1;
    chk("unknown op", {storeValid, addrError, debugBreak, debugModeBreak}, 4'h0);
    rdReg(cmp16_pkg::ADDR_STAT);
    chk("unknown op flags", readVal[9:8], 2'b00);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    chk("mid reset", {awready, wready, arready, bvalid, rvalid, storeValid, addrError,
        debugBreak, debugModeBreak}, 32'h000001c0);
    nrst <= 1'b1;
    rdReg(cmp16_pkg::ADDR_CFG);
    chk("cfg after reset", readVal, 32'h0);
    rdReg(gA(5'h11));
    chk("reg after reset", readVal, 32'h0);
    closeOut();
  end
endmodule
